/* File: pwh_handler.sv */
`timescale 1ns/1ps
module pwh_handler (
    input wire logic clock,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    output pwh_pkg::pwh_store_req_t st_out,
    input wire logic st_known,
    input wire logic st_is_wide,
    input wire logic st_ack,
    input wire logic st_fail
);
    pwh_pkg::pwh_regs_t s_reg;
    pwh_pkg::pwh_regs_t s_next;
    logic [3:0] set_num;
    logic [11:0] par_num;
    logic out_of_range;
    logic size_ok;
    logic [7:0] chk_exc;

    // ------------------------------------------------------------
    // Address decode and request checks
    // ------------------------------------------------------------
    // parameter field
    assign par_num = s_reg.addr[pwh_pkg::ADDR_PARAM_LSB +:
                                pwh_pkg::ADDR_PARAM_W];
    assign set_num = s_reg.addr[pwh_pkg::ADDR_SET_LSB +:
                                pwh_pkg::ADDR_SET_W];
    assign out_of_range = (set_num > pwh_pkg::SET_MAX) ||
                          (par_num > pwh_pkg::PARAM_MAX);

    // Size check per function; the store says the true width
    always_comb begin
        size_ok = 1'b0;
        if (s_reg.fc == pwh_pkg::FC_WRITE_SINGLE) begin
            size_ok = (s_reg.nval == 3'h2) && !st_is_wide;
        end else if (st_is_wide) begin
            size_ok = (s_reg.rcnt == pwh_pkg::REGS_WIDE) &&
                      (s_reg.bcnt == pwh_pkg::BYTES_WIDE) &&
                      (s_reg.nval == 3'h4);
        end else begin
            size_ok = (s_reg.rcnt == pwh_pkg::REGS_NARROW) &&
                      (s_reg.bcnt == pwh_pkg::BYTES_NARROW) &&
                      (s_reg.nval == 3'h2);
        end
    end

    // Priority: function, then address, then size
    always_comb begin
        if (s_reg.fc != pwh_pkg::FC_WRITE_SINGLE &&
            s_reg.fc != pwh_pkg::FC_WRITE_MULTI) begin
            chk_exc = pwh_pkg::EXC_BAD_FUNCTION;
        end else if (out_of_range || !st_known) begin
            chk_exc = pwh_pkg::EXC_BAD_ADDRESS;
        // wrong byte count for the width
        end else if (!size_ok) begin
            chk_exc = pwh_pkg::EXC_BAD_VALUE;
        end else begin
            chk_exc = pwh_pkg::EXC_NONE;
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        case (s_reg.state)
            pwh_pkg::PWH_RX: begin
                if (rx_valid) begin
                    case (s_reg.pos)
                        pwh_pkg::POS_TID_HI: s_next.tid[15:8] = rx_data;
                        pwh_pkg::POS_TID_LO: s_next.tid[7:0] = rx_data;
                        pwh_pkg::POS_PID_HI: s_next.pid[15:8] = rx_data;
                        pwh_pkg::POS_PID_LO: s_next.pid[7:0] = rx_data;
                        // unit byte held only for the echo
                        pwh_pkg::POS_UNIT: s_next.unit = rx_data;
                        pwh_pkg::POS_FC: s_next.fc = rx_data;
                        pwh_pkg::POS_ADDR_HI: s_next.addr[15:8] = rx_data;
                        pwh_pkg::POS_ADDR_LO: s_next.addr[7:0] = rx_data;
                        default: begin
                        end
                    endcase
                    if (s_reg.fc == pwh_pkg::FC_WRITE_MULTI &&
                        s_reg.pos >= pwh_pkg::POS_CNT_HI &&
                        s_reg.pos <= pwh_pkg::POS_BCNT) begin
                        if (s_reg.pos == pwh_pkg::POS_CNT_HI) begin
                            s_next.rcnt[15:8] = rx_data;
                        end else if (s_reg.pos == pwh_pkg::POS_CNT_LO) begin
                            s_next.rcnt[7:0] = rx_data;
                        end else begin
                            s_next.bcnt = rx_data;
                        end
                    end else if (s_reg.pos > pwh_pkg::POS_ADDR_LO) begin
                        // Value bytes; every byte shifts into val, the count stops at VAL_MAX
                        s_next.val = {s_reg.val[23:0], rx_data};
                        if (s_reg.nval != pwh_pkg::VAL_MAX) begin
                            s_next.nval = s_reg.nval + 3'h1;
                        end
                    end
                    if (s_reg.pos != pwh_pkg::POS_MAX) begin
                        s_next.pos = s_reg.pos + 4'h1;
                    end
                    if (rx_last) begin
                        s_next.pos = 4'h0;
                        // Frames ending before the function code drop
                        if (s_reg.pos >= pwh_pkg::POS_FC) begin
                            s_next.state = pwh_pkg::PWH_CHECK;
                        end else begin
                            s_next.val = 32'h0;
                            s_next.nval = 3'h0;
                        end
                    end
                end
            end
            pwh_pkg::PWH_CHECK: begin
                s_next.exc = chk_exc;
                s_next.wide = st_is_wide;
                if (chk_exc == pwh_pkg::EXC_NONE) begin
                    // accepted write, single or multiple, goes to the store
                    s_next.st_req = 1'b1;
                    s_next.state = pwh_pkg::PWH_WRITE;
                end else begin
                    s_next.state = pwh_pkg::PWH_SEND;
                end
            end
            pwh_pkg::PWH_WRITE: begin
                if (st_ack) begin
                    s_next.st_req = 1'b0;
                    if (st_fail) begin
                        s_next.exc = pwh_pkg::EXC_STORE_FAIL;
                    end
                    s_next.state = pwh_pkg::PWH_SEND;
                end
            end
            pwh_pkg::PWH_SEND: begin
                if (tx_ready) begin
                    s_next.resp = {s_reg.resp[87:0], 8'h00};
                    s_next.left = s_reg.left - 4'h1;
                    if (s_reg.left == 4'h1) begin
                        s_next.state = pwh_pkg::PWH_RX;
                        s_next.val = 32'h0;
                        s_next.nval = 3'h0;
                        s_next.rcnt = 16'h0;
                        s_next.bcnt = 8'h0;
                    end
                end
            end
            default: begin
                s_next.state = pwh_pkg::PWH_RX;
            end
        endcase
        // one answer per frame that reaches the function code
        // Answer built once, on the way into the send state
        if (s_next.state == pwh_pkg::PWH_SEND &&
            s_reg.state != pwh_pkg::PWH_SEND) begin
            if (s_next.exc == pwh_pkg::EXC_NONE) begin
                // address echoed; count echoed for 16
                s_next.resp = {s_reg.tid, s_reg.pid,
                               pwh_pkg::LEN_NORMAL, s_reg.unit,
                               s_reg.fc, s_reg.addr,
                               (s_reg.fc == pwh_pkg::FC_WRITE_SINGLE) ?
                               s_reg.val[15:0] : s_reg.rcnt};
                s_next.left = pwh_pkg::RESP_NORMAL_BYTES;
            end else begin
                // function code with the top bit set, then the exception code
                s_next.resp = {s_reg.tid, s_reg.pid,
                               pwh_pkg::LEN_EXC, s_reg.unit,
                               s_reg.fc | pwh_pkg::FC_ERROR_FLAG,
                               s_next.exc, 24'h0};
                s_next.left = pwh_pkg::RESP_EXC_BYTES;
            end
        end
    end

    // State register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            s_reg <= '{state: pwh_pkg::PWH_RX, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rx_ready = (s_reg.state == pwh_pkg::PWH_RX);
    assign tx_valid = (s_reg.state == pwh_pkg::PWH_SEND);
    assign tx_data = s_reg.resp[95:88];
    assign tx_last = tx_valid && (s_reg.left == 4'h1);
    // value passes unscaled to the store
    assign st_out.req = s_reg.st_req;
    assign st_out.dataset = set_num;
    assign st_out.param = par_num;
    assign st_out.wide = s_reg.wide;
    assign st_out.data = s_reg.val;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence frame_done;
        rx_valid && rx_ready && rx_last && s_reg.pos >= pwh_pkg::POS_FC;
    endsequence
    sequence enter_send;
        tx_valid && !$past(tx_valid);
    endsequence
    sequence store_waiting;
        st_out.req && !st_ack;
    endsequence

    a_param_range: assert property (
        @(posedge clock) disable iff (rst)
        st_out.req |-> st_out.param <= pwh_pkg::PARAM_MAX)
        else $error("store request with parameter out of range");
    a_dataset_range: assert property (
        @(posedge clock) disable iff (rst)
        st_out.req |-> st_out.dataset <= pwh_pkg::SET_MAX)
        else $error("store request with dataset out of range");
    a_ident_echo: assert property (
        @(posedge clock) disable iff (rst)
        enter_send |-> tx_data == s_reg.tid[15:8] &&
                       s_reg.resp[79:64] == s_reg.pid)
        else $error("answer does not start with the identifiers");
    a_error_code: assert property (
        @(posedge clock) disable iff (rst)
        enter_send ##0 (s_reg.exc != pwh_pkg::EXC_NONE) |->
            s_reg.left == pwh_pkg::RESP_EXC_BYTES &&
            s_reg.resp[39:32] == (s_reg.fc | pwh_pkg::FC_ERROR_FLAG) &&
            s_reg.resp[31:24] == s_reg.exc)
        else $error("exception answer malformed");
    a_single_echo: assert property (
        @(posedge clock) disable iff (rst)
        enter_send ##0 (s_reg.exc == pwh_pkg::EXC_NONE &&
                        s_reg.fc == pwh_pkg::FC_WRITE_SINGLE) |->
            s_reg.left == pwh_pkg::RESP_NORMAL_BYTES &&
            s_reg.resp[15:0] == s_reg.val[15:0])
        else $error("single write echo wrong");
    a_store_fail: assert property (
        @(posedge clock) disable iff (rst)
        st_out.req && st_ack && st_fail |=>
            s_reg.exc == pwh_pkg::EXC_STORE_FAIL && tx_valid)
        else $error("store failure not answered with code 4");
    a_no_store_bad: assert property (
        @(posedge clock) disable iff (rst)
        s_reg.state == pwh_pkg::PWH_CHECK && out_of_range &&
        (s_reg.fc == pwh_pkg::FC_WRITE_SINGLE ||
         s_reg.fc == pwh_pkg::FC_WRITE_MULTI) |=>
            (!st_out.req && s_reg.exc == pwh_pkg::EXC_BAD_ADDRESS) [*2])
        else $error("out of range address reached the store");
    a_one_answer: assert property (
        @(posedge clock) disable iff (rst)
        frame_done |=> !rx_ready ##1 (tx_valid || st_out.req))
        else $error("complete frame not followed by an answer");
    a_wide_size: assert property (
        @(posedge clock) disable iff (rst)
        s_reg.state == pwh_pkg::PWH_CHECK && !out_of_range &&
        st_known && s_reg.fc == pwh_pkg::FC_WRITE_MULTI &&
        st_is_wide && s_reg.bcnt != pwh_pkg::BYTES_WIDE |=>
            s_reg.exc == pwh_pkg::EXC_BAD_VALUE)
        else $error("wrong byte count not answered with code 3");
    a_multi_echo: assert property (
        @(posedge clock) disable iff (rst)
        enter_send ##0 (s_reg.exc == pwh_pkg::EXC_NONE &&
                        s_reg.fc == pwh_pkg::FC_WRITE_MULTI) |->
            s_reg.left == pwh_pkg::RESP_NORMAL_BYTES &&
            s_reg.resp[31:16] == s_reg.addr &&
            s_reg.resp[15:0] == s_reg.rcnt)
        else $error("multiple write echo wrong");
    // Store sees one settled request until it answers
    a_store_hold: assert property (
        @(posedge clock) disable iff (rst)
        store_waiting |=> st_out.req && $stable(st_out.data) &&
            $stable(st_out.param) && $stable(st_out.wide))
        else $error("store request changed before acknowledge");
    a_wide_counts: assert property (
        @(posedge clock) disable iff (rst)
        st_out.req && st_out.wide |->
            s_reg.rcnt == pwh_pkg::REGS_WIDE &&
            s_reg.bcnt == pwh_pkg::BYTES_WIDE && s_reg.nval == 3'h4)
        else $error("wide store without wide counts");
endmodule

/* File: pwh_handler_tb.sv */
`timescale 1ns/1ps
module pwh_handler_tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic rx_valid = 1'b0;
    logic [7:0] rx_data = 8'h00;
    logic rx_last = 1'b0;
    logic tx_ready = 1'b1;
    logic [3:0] ack_delay = 4'h1;
    logic fail_now = 1'b0;
    logic stall = 1'b0;
    logic rx_ready, tx_valid, tx_last, st_known, st_is_wide, st_ack, st_fail;
    logic [7:0] tx_data;
    logic [7:0] n_writes;
    logic [31:0] last_data;
    logic [15:0] last_addr;
    logic last_wide;
    pwh_pkg::pwh_store_req_t st_out;
    logic [15:0] tid = 16'h1a00;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;

    pwh_handler dut_u (.clock(clock), .rst(rst), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
        .tx_ready(tx_ready), .st_out(st_out), .st_known(st_known),
        .st_is_wide(st_is_wide), .st_ack(st_ack), .st_fail(st_fail));
    pwh_store_model store_u (.clock(clock), .rst(rst), .st_out(st_out),
        .ack_delay(ack_delay), .fail_now(fail_now), .st_known(st_known),
        .st_is_wide(st_is_wide), .st_ack(st_ack), .st_fail(st_fail),
        .last_data(last_data), .last_addr(last_addr),
        .last_wide(last_wide), .n_writes(n_writes));

    // ----------------------------------------
    // Clock, watchdog and reporting
    // ----------------------------------------
    always #20 clock = ~clock;

    // A hung handshake would otherwise stall the run forever
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        comparisons++;
        if (seen !== expd) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
        end
    endtask

    // ----------------------------------------
    // Frame driver and answer collector
    // ----------------------------------------
    // Byte is held until a settled rx_ready lets the next edge take it
    task automatic send_byte(input logic [7:0] b, input logic last);
        int n;
        rx_valid = 1'b1;
        rx_data = b;
        rx_last = last;
        n = 0;
        while (rx_ready !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
    endtask

    // One request out, whole answer in, store effect judged
    task automatic do_req(input logic [7:0] fc, input logic [7:0] unit,
        input logic [15:0] addr, input logic [15:0] cnt,
        input logic [7:0] bc, input logic [31:0] val, input int nv,
        input logic [7:0] exc);
        logic [7:0] q[$];
        logic [7:0] e[$];
        logic [7:0] r[$];
        logic [15:0] pid;
        logic [15:0] w;
        logic [7:0] nw;
        int n;
        logic done;
        logic [31:0] kept;
        tid = tid + 16'h0101;
        pid = {8'h00, tid[7:0]};
        nw = n_writes;
        done = 1'b0;
        q = {tid[15:8], tid[7:0], pid[15:8], pid[7:0], 8'h00, 8'h06, unit,
             fc, addr[15:8], addr[7:0]};
        if (fc == 8'h10)
            q = {q, cnt[15:8], cnt[7:0], bc};
        for (int i = nv - 1; i >= 0; i--)
            q.push_back(val[8*i +: 8]);
        w = (fc == 8'h06) ? val[15:0] : cnt;
        e = {tid[15:8], tid[7:0], pid[15:8], pid[7:0], 8'h00};
        if (exc == 8'h00)
            e = {e, 8'h06, unit, fc, addr[15:8], addr[7:0], w[15:8], w[7:0]};
        else
            e = {e, 8'h03, unit, fc | 8'h80, exc};
        foreach (q[i])
            send_byte(q[i], i == q.size() - 1);
        rx_valid = 1'b0;
        rx_last = 1'b0;
        n = 0;
        while (n < 300 && !done) begin
            tx_ready = !stall || n[0];
            if (tx_valid === 1'b1 && tx_ready) begin
                r.push_back(tx_data);
                done = (tx_last === 1'b1);
            end
            @(negedge clock);
            n++;
        end
        tx_ready = 1'b1;
        check(done, 1'b1);
        check(32'(r.size()), 32'(e.size()));
        foreach (e[i])
            check(i < r.size() ? r[i] : 8'h00 ^ ~e[i], e[i]);
        check(rx_ready, 1'b1);
        if (exc == 8'h00 || exc == 8'h04) begin
            kept = (cnt == 16'h0002) ? last_data : {16'h0, last_data[15:0]};
            check(n_writes, nw + 8'h01);
            check(last_addr, addr);
            check(last_wide, cnt == 16'h0002);
            check(kept, val);
        end else
            check(n_writes, nw);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_single16();
        do_req(8'h06, 8'h01, 16'h2174, 16'h0000, 8'h00, 32'h67, 2,
               8'h00);
    endtask
    task automatic t_multi16();
        do_req(8'h10, 8'h02, 16'h9000, 16'h0001, 8'h02, 32'h1234, 2,
               8'h00);
    endtask
    task automatic t_multi32();
        ack_delay = 4'h0;
        do_req(8'h10, 8'h03, 16'h963f, 16'h0002, 8'h04, 32'hdead3039, 4,
               8'h00);
    endtask
    task automatic t_range();
        do_req(8'h06, 8'h04, 16'h0640, 16'h0000, 8'h00, 32'h1, 2,
               8'h02);
        do_req(8'h10, 8'h05, 16'ha000, 16'h0001, 8'h02, 32'h1, 2,
               8'h02);
    endtask
    // Unsupported function answers code 1 and never reaches the store
    task automatic t_bad_func();
        do_req(8'h03, 8'h0a, 16'h0100, 16'h0001, 8'h00, 32'h2, 2,
               8'h01);
    endtask
    task automatic t_unknown();
        do_req(8'h06, 8'h06, 16'h10aa, 16'h0000, 8'h00, 32'h5, 2,
               8'h02);
    endtask
    task automatic t_size();
        do_req(8'h10, 8'h07, 16'h0400, 16'h0001, 8'h02, 32'h9, 2,
               8'h03);
        do_req(8'h06, 8'h08, 16'h0400, 16'h0000, 8'h00, 32'h9, 2,
               8'h03);
    endtask
    task automatic t_fail();
        ack_delay = 4'h5;
        fail_now = 1'b1;
        do_req(8'h06, 8'h09, 16'h0123, 16'h0000, 8'h00, 32'h77, 2,
               8'h04);
        fail_now = 1'b0;
    endtask
    // Frame cut before the function code draws no answer
    task automatic t_short();
        for (int i = 0; i < 5; i++)
            send_byte(8'h40 + 8'(i), i == 4);
        rx_valid = 1'b0;
        rx_last = 1'b0;
        repeat (4) begin
            @(negedge clock);
            check(tx_valid, 1'b0);
        end
        check(rx_ready, 1'b1);
    endtask
    task automatic t_stall();
        stall = 1'b1;
        do_req(8'h06, 8'hf7, 16'h3005, 16'h0000, 8'h00, 32'hffff, 2,
               8'h00);
        stall = 1'b0;
    endtask

    initial begin
        repeat (3) @(negedge clock);
        rst = 1'b0;
        check(tx_valid, 1'b0);
        check(rx_ready, 1'b1);
        t_single16();
        t_multi16();
        t_multi32();
        t_range();
        t_bad_func();
        t_unknown();
        t_size();
        t_fail();
        t_short();
        t_stall();
        tally_and_finish();
    end
endmodule

/* File: pwh_pkg.sv */
package pwh_pkg;
    // Function codes and exception answers
    localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
    localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
    localparam logic [7:0] FC_ERROR_FLAG = 8'h80;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_BAD_FUNCTION = 8'h01;
    localparam logic [7:0] EXC_BAD_ADDRESS = 8'h02;
    localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
    localparam logic [7:0] EXC_STORE_FAIL = 8'h04;
    // Start address split
    localparam int ADDR_PARAM_LSB = 0;
    localparam int ADDR_PARAM_W = 12;
    localparam int ADDR_SET_LSB = 12;
    localparam int ADDR_SET_W = 4;
    localparam logic [11:0] PARAM_MAX = 12'h63f;
    localparam logic [3:0] SET_MAX = 4'h9;
    // Counts for the two widths of function 16
    localparam logic [15:0] REGS_NARROW = 16'h0001;
    localparam logic [15:0] REGS_WIDE = 16'h0002;
    localparam logic [7:0] BYTES_NARROW = 8'h02;
    localparam logic [7:0] BYTES_WIDE = 8'h04;
    // Byte positions inside a request frame
    localparam logic [3:0] POS_TID_HI = 4'h0;
    localparam logic [3:0] POS_TID_LO = 4'h1;
    localparam logic [3:0] POS_PID_HI = 4'h2;
    localparam logic [3:0] POS_PID_LO = 4'h3;
    localparam logic [3:0] POS_UNIT = 4'h6;
    localparam logic [3:0] POS_FC = 4'h7;
    localparam logic [3:0] POS_ADDR_HI = 4'h8;
    localparam logic [3:0] POS_ADDR_LO = 4'h9;
    localparam logic [3:0] POS_CNT_HI = 4'ha;
    localparam logic [3:0] POS_CNT_LO = 4'hb;
    localparam logic [3:0] POS_BCNT = 4'hc;
    localparam logic [3:0] POS_MAX = 4'hf;
    // Response lengths: total bytes, and the header length field
    localparam logic [3:0] RESP_NORMAL_BYTES = 4'hc;
    localparam logic [3:0] RESP_EXC_BYTES = 4'h9;
    localparam logic [15:0] LEN_NORMAL = 16'h0006;
    localparam logic [15:0] LEN_EXC = 16'h0003;
    localparam logic [2:0] VAL_MAX = 3'h7;

    typedef enum logic [3:0] {
        PWH_RX = 4'b0001,
        PWH_CHECK = 4'b0010,
        PWH_WRITE = 4'b0100,
        PWH_SEND = 4'b1000
    } pwh_state_t;

    typedef struct packed {
        pwh_state_t state;
        logic [3:0] pos;
        logic [15:0] tid;
        logic [15:0] pid;
        logic [7:0] unit;
        logic [7:0] fc;
        logic [15:0] addr;
        logic [15:0] rcnt;
        logic [7:0] bcnt;
        logic [31:0] val;
        logic [2:0] nval;
        logic [7:0] exc;
        logic wide;
        logic st_req;
        logic [95:0] resp;
        logic [3:0] left;
    } pwh_regs_t;

    // Parameter store write port
    typedef struct packed {
        logic req;
        logic [3:0] dataset;
        logic [11:0] param;
        logic wide;
        logic [31:0] data;
    } pwh_store_req_t;
endpackage

/* File: pwh_store_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Parameter store seen by the handler
// ----------------------------------------
module pwh_store_model (
    input wire logic clock,
    input wire logic rst,
    input wire pwh_pkg::pwh_store_req_t st_out,
    input wire logic [3:0] ack_delay,
    input wire logic fail_now,
    output logic st_known,
    output logic st_is_wide,
    output logic st_ack,
    output logic st_fail,
    output logic [31:0] last_data,
    output logic [15:0] last_addr,
    output logic last_wide,
    output logic [7:0] n_writes
);
    logic [3:0] wait_reg;
    logic fire;

    // one missing slot
    // Slot 0x0aa is absent, bit 10 marks 32-bit slots
    assign st_known = (st_out.param != 12'h0aa);
    assign st_is_wide = st_out.param[10];
    assign fire = st_out.req && !st_ack && (wait_reg == ack_delay);

    // whole value, failure
    // Wait is set by the bench so slow stores are exercised too
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wait_reg <= 4'h0;
            st_ack <= 1'b0;
            st_fail <= 1'b0;
            n_writes <= 8'h00;
            last_data <= 32'h0;
            last_addr <= 16'h0;
            last_wide <= 1'b0;
        end else begin
            st_ack <= fire;
            st_fail <= fire && fail_now;
            wait_reg <= (st_out.req && !st_ack) ? wait_reg + 4'h1 : 4'h0;
            if (st_out.req && st_ack) begin
                n_writes <= n_writes + 8'h01;
                last_data <= st_out.data;
                last_addr <= {st_out.dataset, st_out.param};
                last_wide <= st_out.wide;
            end
        end
    end
endmodule
